// >>> src/serial_cfg_pkg.sv
// constants for the serial interface configuration register bank
package serial_cfg_pkg;
    // register addresses (8-bit register space)
    localparam logic [7:0] addr_source_id_chan0     = 8'h1a;
    localparam logic [7:0] addr_source_id_chan1     = 8'h1b;
    localparam logic [7:0] addr_serial_frame_config = 8'h3d;
    localparam logic [7:0] addr_product_identity    = 8'h3e;
    localparam logic [7:0] addr_client_bus_address  = 8'h3f;
    // shared otp window: base address and first region code
    localparam logic [7:0] shared_block_base        = 8'ha0;
    localparam logic [3:0] region_code_first        = 4'ha;
    // reset values
    localparam logic [7:0] source_id_reset          = 8'h00;
    localparam logic [7:0] frame_config_reset       = 8'h00;
    localparam logic [7:0] identity_reset           = 8'h00;
    localparam logic [7:0] client_addr_reset        = 8'h00;
    localparam logic [3:0] region_load_reset        = 4'he;
    // identity code returned while stored value is zero (value arbitrary)
    localparam logic [7:0] identity_default_code    = 8'h5a;
    localparam logic [7:0] client_addr_default      = 8'h60;
    // field positions
    localparam int         src_enable_bit           = 7;
    localparam int         field_width_bit          = 6;
    localparam int         check_len_lsb            = 4;
    // crc length codes
    localparam logic [1:0] check_len_crc8           = 2'b00;
    localparam logic [1:0] check_len_crc4           = 2'b01;
    // crc polynomials (implicit top bit) and default seeds
    localparam logic [7:0] crc8_poly                = 8'h2f;
    localparam logic [7:0] crc4_poly                = 8'h01;
    localparam logic [7:0] crc3_poly                = 8'h03;
    localparam logic [7:0] crc8_seed_default        = 8'hff;
    localparam logic [7:0] crc4_seed_default        = 8'h0a;
    localparam logic [7:0] crc3_seed_default        = 8'h07;
    // crc and data field width codes presented to the frame logic
    localparam logic [3:0] crc8_width               = 4'h8;
    localparam logic [3:0] crc4_width               = 4'h4;
    localparam logic [3:0] crc3_width               = 4'h3;
    localparam logic [4:0] field_width_narrow       = 5'h0c;
    localparam logic [4:0] field_width_wide         = 5'h10;
endpackage

// >>> src/serial_interface_config_regs.sv
// serial interface configuration registers with shared window aliasing
//
// Behaviour
// R1: window reads use low nibble, no error
// R2: after init lock, only reset bits writable
// R3: host selects window before init lock
// R4: source tag regs: enable bit7, tag 3:0
// R5: spi: enable picks sensor word or error
// R6: i2c: enables drive read wrap-around
// R7: i2c: source regs have no other effect
// R8: width bit selects 12 or 16 bits
// R9: length field selects crc polynomial
// R10: zero seed gives per-length default seed
// R11: nonzero seed used, widened or trimmed
// R12: new crc settings apply next command
// R13: identity reads code while stored zero
// R14: client address 60h while stored zero
// R15: client address readable in all modes
// R16: these registers feed array error check
// R17: frame config writable from either interface
// R18: region codes Ah-Fh map A0h-FFh ranges
// R19: reserved bits store and read back
`timescale 1ns/1ps
module serial_interface_config_regs
    import serial_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // interface mode and register bus
    input  wire logic        i2c_mode,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    // reset control write and init lock, both from the control bank
    input  wire logic        reset_bits_wr,
    input  wire logic        init_done_lock,
    // shared window: active region code and mirror data
    input  wire logic [3:0]  region_active,
    input  wire logic [7:0]  shared_rdata,
    // strobe at the start of each spi command
    input  wire logic        cmd_start,
    // registered read answer and mirror address
    output logic      [7:0]  reg_rdata,
    output logic             reg_hit,
    output logic      [7:0]  shared_addr,
    // source mapping for the spi frame and i2c wrap-around
    output logic             chan0_source_enable,
    output logic             chan1_source_enable,
    output logic      [3:0]  source_tag_chan0,
    output logic      [3:0]  source_tag_chan1,
    output logic             chan0_send_data,
    output logic             chan1_send_data,
    output logic      [1:0]  read_wrap_sel,
    // frame settings held for the command in flight
    output logic      [4:0]  frame_width,
    output logic      [3:0]  crc_width,
    output logic      [7:0]  crc_poly,
    output logic      [7:0]  crc_seed,
    // client address and stored bytes for the array check
    output logic      [6:0]  bus_address,
    output logic      [39:0] check_array
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    // stored bytes and their next values
    logic [7:0] src0_reg;
    logic [7:0] src0_next;
    logic [7:0] src1_reg;
    logic [7:0] src1_next;
    logic [7:0] frame_reg;
    logic [7:0] frame_next;
    logic [7:0] ident_reg;
    logic [7:0] ident_next;
    logic [7:0] client_reg;
    logic [7:0] client_next;
    // crc and field settings held for the command in flight
    logic [3:0] crc_width_reg;
    logic [3:0] crc_width_next;
    logic [7:0] crc_poly_reg;
    logic [7:0] crc_poly_next;
    logic [7:0] crc_seed_reg;
    logic [7:0] crc_seed_next;
    logic [4:0] width_reg;
    logic [4:0] width_next;
    // registered read answer
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       hit_reg;
    logic       hit_next;
    // decode helpers
    logic       wr_ok;
    logic [3:0] len_width;
    logic [7:0] len_poly;
    logic [7:0] len_seed;
    logic [1:0] len_sel;
    logic [3:0] seed_field;
    logic       in_shared;

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    // writes blocked once init lock is set; the reset bits live elsewhere
    // and are taken on reset_bits_wr, which this bank does not gate
    // R2: write lockout
    assign wr_ok = reg_wr && !init_done_lock;

    // write path; all eight bits stored so reserved bits read back
    always_comb begin
        src0_next   = src0_reg;
        src1_next   = src1_reg;
        frame_next  = frame_reg;
        ident_next  = ident_reg;
        client_next = client_reg;
        if (wr_ok) begin
            unique case (reg_addr)
                // R4: tag register layout
                // R19: reserved bits kept
                addr_source_id_chan0: begin
                    src0_next = reg_wdata;
                end
                addr_source_id_chan1: begin
                    src1_next = reg_wdata;
                end
                // R17: writable from either mode
                addr_serial_frame_config: begin
                    frame_next = reg_wdata;
                end
                addr_product_identity: begin
                    ident_next = reg_wdata;
                end
                addr_client_bus_address: begin
                    client_next = reg_wdata;
                end
                default: begin
                    src0_next = src0_reg;
                end
            endcase
        end
    end

    // async reset clears every byte; a write shows one edge later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            src0_reg   <= source_id_reset;
            src1_reg   <= source_id_reset;
            frame_reg  <= frame_config_reset;
            ident_reg  <= identity_reset;
            client_reg <= client_addr_reset;
        end else begin
            src0_reg   <= src0_next;
            src1_reg   <= src1_next;
            frame_reg  <= frame_next;
            ident_reg  <= ident_next;
            client_reg <= client_next;
        end
    end

    // ------------------------------------------------------------
    // crc and frame selection
    // ------------------------------------------------------------
    // length and seed fields of the frame config byte
    assign len_sel    = frame_reg[check_len_lsb +: 2];
    assign seed_field = frame_reg[3:0];

    // decode length and seed from the stored field; codes 10 and 11 both
    // give the 3-bit crc, so no length code is illegal
    always_comb begin
        // R9: polynomial by length code
        // R10: default seeds
        // R11: programmed seeds
        unique case (len_sel)
            check_len_crc8: begin
                len_width = crc8_width;
                len_poly  = crc8_poly;
                if (seed_field == 4'h0) begin
                    len_seed = crc8_seed_default;
                end else begin
                    len_seed = {4'h0, seed_field};
                end
            end
            check_len_crc4: begin
                len_width = crc4_width;
                len_poly  = crc4_poly;
                if (seed_field == 4'h0) begin
                    len_seed = crc4_seed_default;
                end else begin
                    len_seed = {4'h0, seed_field};
                end
            end
            default: begin
                len_width = crc3_width;
                len_poly  = crc3_poly;
                // the 3-bit crc drops the top seed bit
                if (seed_field == 4'h0) begin
                    len_seed = crc3_seed_default;
                end else begin
                    len_seed = {5'h00, seed_field[2:0]};
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // settings for the command in flight
    // ------------------------------------------------------------
    // settings latched only at command start so a command in flight
    // never sees its polynomial change half-way
    always_comb begin
        crc_width_next = crc_width_reg;
        crc_poly_next  = crc_poly_reg;
        crc_seed_next  = crc_seed_reg;
        width_next     = width_reg;
        // R12: apply at next command
        if (cmd_start) begin
            crc_width_next = len_width;
            crc_poly_next  = len_poly;
            crc_seed_next  = len_seed;
            // the width follows the same rule so a field and its crc agree
            // R8: data field width
            width_next     = frame_reg[field_width_bit] ? field_width_wide
                                                        : field_width_narrow;
        end
    end

    // reset state is the 8-bit crc with its default seed and a 12-bit field
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            crc_width_reg <= crc8_width;
            crc_poly_reg  <= crc8_poly;
            crc_seed_reg  <= crc8_seed_default;
            width_reg     <= field_width_narrow;
        end else begin
            crc_width_reg <= crc_width_next;
            crc_poly_reg  <= crc_poly_next;
            crc_seed_reg  <= crc_seed_next;
            width_reg     <= width_next;
        end
    end

    // held settings out to the frame logic
    assign crc_width   = crc_width_reg;
    assign crc_poly    = crc_poly_reg;
    assign crc_seed    = crc_seed_reg;
    assign frame_width = width_reg;

    // ------------------------------------------------------------
    // source mapping
    // ------------------------------------------------------------
    // enable bit and tag straight from the stored bytes; bits 6:4 unused
    assign chan0_source_enable = src0_reg[src_enable_bit];
    assign chan1_source_enable = src1_reg[src_enable_bit];
    assign source_tag_chan0    = src0_reg[3:0];
    assign source_tag_chan1    = src1_reg[3:0];
    // R5: enable picks data or error
    // R7: no spi effect in i2c mode
    assign chan0_send_data = !i2c_mode && chan0_source_enable;
    assign chan1_send_data = !i2c_mode && chan1_source_enable;
    // R6: wrap-around control in i2c
    assign read_wrap_sel   = i2c_mode ? {chan1_source_enable, chan0_source_enable} : 2'b00;

    // R14: responding client address
    // a blank store still answers at 60h so a fresh part can be reached;
    // bit 7 of a programmed value is kept for read-back and the array check only
    assign bus_address = (client_reg == 8'h00) ? client_addr_default[6:0]
                                               : client_reg[6:0];

    // R16: contents to the array check
    // bytes packed in address order, highest address on top
    assign check_array = {client_reg, ident_reg, frame_reg, src1_reg, src0_reg};

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // R18: active region selects base
    // R1: low nibble only, no error
    assign in_shared   = (reg_addr >= shared_block_base);
    assign shared_addr = {region_active, reg_addr[3:0]};

    // read data is registered one cycle after reg_rd
    always_comb begin
        rdata_next = rdata_reg;
        hit_next   = 1'b0;
        if (reg_rd) begin
            hit_next = 1'b1;
            unique case (reg_addr)
                // R4: tag bytes read whole
                // R19: reserved bits returned
                addr_source_id_chan0: begin
                    rdata_next = src0_reg;
                end
                addr_source_id_chan1: begin
                    rdata_next = src1_reg;
                end
                // R17: readable from either mode
                addr_serial_frame_config: begin
                    rdata_next = frame_reg;
                end
                // R13: identity default code
                addr_product_identity: begin
                    if (ident_reg == 8'h00) begin
                        rdata_next = identity_default_code;
                    end else begin
                        rdata_next = ident_reg;
                    end
                end
                // R15: readable in every mode
                // R14: blank store reads 60h
                addr_client_bus_address: begin
                    if (client_reg == 8'h00) begin
                        rdata_next = client_addr_default;
                    end else begin
                        rdata_next = client_reg;
                    end
                end
                default: begin
                    // outside the window, or with a reserved region code,
                    // the read is unmapped: zero data and no hit
                    if (in_shared && region_active >= region_code_first) begin
                        rdata_next = shared_rdata;
                    end else begin
                        rdata_next = 8'h00;
                        hit_next   = 1'b0;
                    end
                end
            endcase
        end
    end

    // answer held until the next read; hit is a one-cycle pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
            hit_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            hit_reg   <= hit_next;
        end
    end

    // registered answer out
    assign reg_rdata = rdata_reg;
    assign reg_hit   = hit_reg;

endmodule

// >>> tb/otp_mirror_model.sv
// shared otp mirror model answering window reads
`timescale 1ns/1ps
module otp_mirror_model #(
    parameter logic [7:0] mask = 8'h5c
) (
    input  wire logic [7:0] shared_addr,
    output logic      [7:0] shared_rdata
);
    // data per address
    // distinct pattern per address so a wrong alias shows up
    assign shared_rdata = shared_addr ^ mask;
endmodule

// >>> tb/serial_cfg_chk.sv
// port checks for the configuration register bank
`timescale 1ns/1ps
module serial_cfg_chk
    import serial_cfg_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        i2c_mode,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic        init_done_lock,
    input wire logic [3:0]  region_active,
    input wire logic        cmd_start,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    input wire logic [7:0]  shared_addr,
    input wire logic        chan0_source_enable,
    input wire logic        chan1_source_enable,
    input wire logic        chan0_send_data,
    input wire logic [1:0]  read_wrap_sel,
    input wire logic [4:0]  frame_width,
    input wire logic [3:0]  crc_width,
    input wire logic [7:0]  crc_poly,
    input wire logic [6:0]  bus_address,
    input wire logic [39:0] check_array
);
    // ----------
    // assertions
    // ----------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // identity read while the store is zero, then its answer
    sequence s_ident_rd;
        reg_rd && reg_addr == addr_product_identity && check_array[31:24] == 8'h00;
    endsequence
    sequence s_ident_ans;
        reg_hit && reg_rdata == identity_default_code;
    endsequence
    a_window_alias: assert property (shared_addr == {region_active, reg_addr[3:0]})
        else $error("window address wrong");
    a_lock_no_write: assert property (reg_wr && init_done_lock |=> $stable(check_array))
        else $error("locked write changed a register");
    a_send_enable: assert property (chan0_send_data == (!i2c_mode && chan0_source_enable))
        else $error("send select wrong");
    a_wrap_select: assert property (read_wrap_sel ==
        (i2c_mode ? {chan1_source_enable, chan0_source_enable} : 2'b00))
        else $error("wrap select wrong");
    a_width_sel: assert property (cmd_start |=> frame_width ==
        ($past(check_array[22]) ? field_width_wide : field_width_narrow))
        else $error("field width wrong");
    a_crc4_sel: assert property (cmd_start && check_array[21:20] == check_len_crc4
        |=> crc_width == crc4_width && crc_poly == crc4_poly)
        else $error("crc4 select wrong");
    a_crc_hold: assert property (!cmd_start |=> $stable(crc_width) && $stable(crc_poly))
        else $error("crc changed without command");
    a_ident_code: assert property (s_ident_rd |=> s_ident_ans)
        else $error("identity code wrong");
    a_bus_addr: assert property (bus_address == (check_array[39:32] == 8'h00 ?
        client_addr_default[6:0] : check_array[38:32]))
        else $error("bus address wrong");
endmodule
bind serial_interface_config_regs serial_cfg_chk chk_i (.*);

// >>> tb/tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb import serial_cfg_pkg::*;;
    logic core_clk = 0, rst = 1, i2c_mode = 0, reg_wr = 0, reg_rd = 0;
    logic reset_bits_wr = 0, init_done_lock = 0, cmd_start = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, shared_addr, shared_rdata, crc_poly;
    logic [3:0] region_active = 4'he, source_tag_chan0, source_tag_chan1, crc_width;
    logic reg_hit, chan0_source_enable, chan1_source_enable, chan0_send_data, chan1_send_data;
    logic [1:0] read_wrap_sel;
    logic [4:0] frame_width;
    logic [7:0] crc_seed;
    logic [6:0] bus_address;
    logic [39:0] check_array;
    logic [31:0] crc_now;
    int errors = 0, total_checks = 0;
    assign crc_now = {4'h0, crc_width, crc_poly, crc_seed, 3'b0, frame_width};
    serial_interface_config_regs uut (.*);
    otp_mirror_model mirror (.shared_addr(shared_addr), .shared_rdata(shared_rdata));
    // ----------------
    // clock and tasks
    // ----------------
    always #4 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read strobe one cycle, answer sampled after the next edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", e, reg_rdata);
        chk("read hit", h, reg_hit);
    endtask
    // expected crc setup and field width for a config byte
    function automatic logic [31:0] crc_exp(input logic [7:0] c);
        logic [3:0] s;
        s = c[3:0];
        case (c[5:4])
            2'b00: crc_exp = {4'h8, 8'h2f, (s == 0) ? 8'hff : {4'h0, s}};
            2'b01: crc_exp = {4'h4, 8'h01, (s == 0) ? 8'h0a : {4'h0, s}};
            default: crc_exp = {4'h3, 8'h03, (s == 0) ? 8'h07 : {5'h0, s[2:0]}};
        endcase
        crc_exp = {crc_exp[19:0], 3'b0, c[6] ? 5'd16 : 5'd12};
    endfunction
    task automatic t_reset;
        rd(addr_source_id_chan0, 8'h00, 1);
        rd(addr_source_id_chan1, 8'h00, 1);
        rd(addr_serial_frame_config, 8'h00, 1);
        rd(addr_product_identity, 8'h5a, 1);
        rd(addr_client_bus_address, 8'h60, 1);
        rd(8'h20, 8'h00, 0);
        $display("test reset done");
    endtask
    task automatic t_source;
        wr(addr_source_id_chan0, 8'hf5);
        wr(addr_source_id_chan1, 8'h7a);
        #1;
        chk("tag0", 5'h15, {chan0_source_enable, source_tag_chan0});
        chk("tag1", 5'h0a, {chan1_source_enable, source_tag_chan1});
        chk("send", 2'b01, {chan1_send_data, chan0_send_data});
        chk("wrap spi", 2'b00, read_wrap_sel);
        rd(addr_source_id_chan0, 8'hf5, 1);
        @(posedge core_clk);
        i2c_mode <= 1'b1;
        #1;
        chk("wrap", 2'b01, read_wrap_sel);
        chk("send i2c", 2'b00, {chan1_send_data, chan0_send_data});
        rd(addr_source_id_chan1, 8'h7a, 1);
        rd(addr_client_bus_address, 8'h60, 1);
        wr(addr_serial_frame_config, 8'h80);
        rd(addr_serial_frame_config, 8'h80, 1);
        @(posedge core_clk);
        i2c_mode <= 1'b0;
        $display("test source done");
    endtask
    task automatic t_ident;
        wr(addr_product_identity, 8'hc3);
        rd(addr_product_identity, 8'hc3, 1);
        wr(addr_client_bus_address, 8'ha4);
        #1;
        chk("bus address", 7'h24, bus_address);
        chk("array", 40'ha4c3807af5, check_array);
        rd(addr_client_bus_address, 8'ha4, 1);
        $display("test identity done");
    endtask
    task automatic t_crc;
        logic [7:0] cfg [8] = '{8'h40, 8'h05, 8'h10, 8'h1b, 8'h20, 8'h2e, 8'h30, 8'h39};
        logic [31:0] prev;
        prev = crc_exp(8'h00);
        foreach (cfg[i]) begin
            wr(addr_serial_frame_config, cfg[i]);
            #1;
            chk("crc before command", prev, crc_now);
            @(posedge core_clk);
            cmd_start <= 1'b1;
            @(posedge core_clk);
            cmd_start <= 1'b0;
            #1;
            prev = crc_exp(cfg[i]);
            chk("crc after command", prev, crc_now);
        end
        rd(addr_serial_frame_config, 8'h39, 1);
        $display("test crc done");
    endtask
    task automatic t_window;
        for (int c = 10; c < 16; c++) begin
            @(posedge core_clk);
            region_active <= 4'(c);
            rd(8'hc2, {4'(c), 4'h2} ^ 8'h5c, 1);
        end
        @(posedge core_clk);
        region_active <= 4'h9;
        rd(8'hc2, 8'h00, 0);
        $display("test window done");
    endtask
    task automatic t_lock;
        @(posedge core_clk);
        region_active <= 4'hb;
        @(posedge core_clk);
        init_done_lock <= 1'b1;
        wr(addr_serial_frame_config, 8'hff);
        wr(addr_client_bus_address, 8'h11);
        @(posedge core_clk);
        reset_bits_wr <= 1'b1;
        @(posedge core_clk);
        reset_bits_wr <= 1'b0;
        rd(addr_serial_frame_config, 8'h39, 1);
        rd(addr_client_bus_address, 8'ha4, 1);
        rd(8'hf7, 8'hb7 ^ 8'h5c, 1);
        $display("test lock done");
    endtask
    // mid-run reset: every register back to its reset value, lock dropped
    task automatic t_rerst;
        @(posedge core_clk);
        rst <= 1'b1;
        init_done_lock <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk("array after reset", 40'h0, check_array);
        chk("crc after reset", crc_exp(8'h00), crc_now);
        chk("address after reset", 7'h60, bus_address);
        rd(addr_product_identity, 8'h5a, 1);
        $display("test mid-run reset done");
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_source;
        t_ident;
        t_crc;
        t_window;
        t_lock;
        t_rerst;
        final_report;
    end
    // watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        errors++;
        final_report;
    end
endmodule
